// file: design/vcg_pkg.sv
/*
  package for the video clock generator control: serial frame layout,
  register addresses, field positions, reset values and timing counts.
  assumes a 125 mhz system clock on both ends.
*/
package vcg_pkg;
  // ---------------------------------------------------------------
  // serial frame
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 15;
  localparam int ADDR_BITS  = 3;
  localparam int DATA_BITS  = 11;
  localparam int NUM_REGS   = 8;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_FB_DIV = 3'h0;
  localparam logic [2:0] ADDR_REF    = 3'h3;
  localparam logic [2:0] ADDR_CTL4   = 3'h4;
  localparam logic [2:0] ADDR_CTL5   = 3'h5;
  localparam logic [2:0] ADDR_TEST   = 3'h6;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int REF_EDGE_POLARITY_BIT   = 10;
  localparam int PD_EN_BIT     = 6;
  localparam int FB_SEL_BIT    = 0;
  localparam int FB_POL_BIT    = 1;
  localparam int ADD_BIT       = 2;
  localparam int REMOVE_BIT    = 3;
  localparam int REF_BUF_BIT   = 6;
  localparam int TEST_EN_BIT   = 0;
  localparam int TEST_CLK_BIT  = 1;
  localparam int TEST_AUX_LSB  = 2;

  // ---------------------------------------------------------------
  // reset values: output runs at half the reference
  // ---------------------------------------------------------------
  localparam logic [10:0] RST_FB_DIV = 11'h04f;
  localparam logic [10:0] RST_LO     = 11'h003;
  localparam logic [10:0] RST_HI     = 11'h006;
  localparam logic [10:0] RST_REF    = 11'h013;
  localparam logic [10:0] RST_CTL4   = 11'h5c4;
  localparam logic [10:0] RST_CTL5   = 11'h031;
  localparam logic [10:0] RST_TEST   = 11'h000;
  localparam logic [10:0] RST_SPARE  = 11'h000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int POR_WAIT_US   = 20;
  localparam int POR_WAIT_CYC  = (POR_WAIT_US * 1000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC = 8;

  typedef enum logic [1:0] {
    HOST_WAIT,
    HOST_IDLE,
    HOST_SHIFT,
    HOST_LATCH
  } vcg_host_state_t;
endpackage

// file: design/vcg_serial_if.sv
/*
  three-wire serial link between host and clock generator.
  resolves the shared data wire from the two enables, device first, high when neither drives.
*/
`timescale 1ns/100ps
interface vcg_serial_if;
  logic sclk;
  logic sel_n;
  logic serial_data_io_host_o;
  logic serial_data_io_host_oe;
  logic serial_data_io_dev_o;
  logic serial_data_io_dev_oe;
  logic serial_data_io;

  assign serial_data_io = serial_data_io_dev_oe ? serial_data_io_dev_o :
                 serial_data_io_host_oe ? serial_data_io_host_o : 1'b1;

  modport host (
    output sclk,
    output sel_n,
    output serial_data_io_host_o,
    output serial_data_io_host_oe,
    input  serial_data_io
  );
  modport device (
    input  sclk,
    input  sel_n,
    output serial_data_io_dev_o,
    output serial_data_io_dev_oe,
    input  serial_data_io
  );
endinterface

// file: design/vcg_edge_sync.sv
/*
  two-flop synchroniser with rise and fall pulses.
  assumes an input asynchronous to ref_clk_i.
*/
`timescale 1ns/100ps
module vcg_edge_sync (
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;

  always_comb begin
    sh_d = {sh_q[1:0], async_i};
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sh_q <= 3'h0;
    end else begin
      sh_q <= sh_d;
    end
  end

  assign level_o = sh_q[1];
  assign rise_o  = sh_q[1] & ~sh_q[2];
  assign fall_o  = ~sh_q[1] & sh_q[2];
endmodule

// file: design/vcg_device.sv
/*
  clock generator control end: serial register port, reference and
  feedback selection, phase detector gating, pixel add/remove and
  board-test overrides. assumes analog loop is outside; pins other than
  aux_func_i are asynchronous to ref_clk_i and are synchronised here.
*/
// What this block does
// - select 0 takes reference from crystal oscillator
// - select 1 routes external reference through buffer
// - polarity 0 locks to reference rising edges
// - host sets divider one for line lock
// - enable pin high tracks, low free-runs
// - feedback select 0 uses external feedback pin
// - feedback polarity 0 locks to rising edges
// - switch to internal feedback at feedback edge
// - pixel phase added or removed by register
// - power-on defaults give half reference output
// - host waits 20 us before programming
// - test mode drives both clock pins statically
// - test mode drives four aux pins statically
// - serial port shifts bits only with select low
// - 15-bit frame: flag, address, data, lsb first
// - serial clock rise with select high commits write or loads read
// - disabled detector ignores reference and feedback
`timescale 1ns/100ps
module vcg_device (
  input  wire logic         ref_clk_i,
  input  wire logic         sys_rst_i,
  vcg_serial_if.device      ser,
  input  wire logic         crystal_osc_i,
  input  wire logic         reference_input_i,
  input  wire logic         ext_feedback_input_i,
  input  wire logic         int_feedback_i,
  input  wire logic         phase_detect_enable_i,
  input  wire logic         pixel_clk_i,
  input  wire logic [3:0]   aux_func_i,
  output logic              pfd_ref_edge_o,
  output logic              pfd_fb_edge_o,
  output logic              fb_is_internal_o,
  output logic              pixel_add_o,
  output logic              pixel_remove_o,
  output logic              clk_p_o,
  output logic              clk_n_o,
  output logic [3:0]        aux_output_o,
  output logic [10:0]       fb_divider_o,
  output logic [10:0]       ref_divider_o
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic sclk_lv, sclk_rise, sel_lv, sd_lv, ref_lv, ref_r, ref_f;
  logic xo_lv, xo_r, xo_f, ext_lv, ext_r, ext_f, int_r, pd_lv;
  logic px_lv, sel_up;

  vcg_edge_sync u_sclk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(ser.sclk), .level_o(sclk_lv), .rise_o(sclk_rise),
    .fall_o());
  vcg_edge_sync u_sel (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(ser.sel_n), .level_o(sel_lv), .rise_o(sel_up), .fall_o());
  vcg_edge_sync u_sd (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(ser.serial_data_io), .level_o(sd_lv), .rise_o(), .fall_o());
  vcg_edge_sync u_ref (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(reference_input_i), .level_o(ref_lv), .rise_o(ref_r),
    .fall_o(ref_f));
  vcg_edge_sync u_xo (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(crystal_osc_i), .level_o(xo_lv), .rise_o(xo_r),
    .fall_o(xo_f));
  vcg_edge_sync u_ext (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(ext_feedback_input_i), .level_o(ext_lv), .rise_o(ext_r),
    .fall_o(ext_f));
  vcg_edge_sync u_int (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(int_feedback_i), .level_o(), .rise_o(int_r), .fall_o());
  vcg_edge_sync u_pd (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(phase_detect_enable_i), .level_o(pd_lv), .rise_o(),
    .fall_o());
  vcg_edge_sync u_px (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .async_i(pixel_clk_i), .level_o(px_lv), .rise_o(), .fall_o());

  // ---------------------------------------------------------------
  // register file and serial shifter
  // ---------------------------------------------------------------
  logic [10:0] regs_q [vcg_pkg::NUM_REGS];
  logic [10:0] regs_d [vcg_pkg::NUM_REGS];
  logic [14:0] shreg_q, shreg_d;
  logic        drive_q, drive_d;
  logic        fb_int_q, fb_int_d;
  logic        add_q, add_d, rem_q, rem_d;
  logic [2:0]  addr;

  function automatic logic [10:0] reset_value(input int idx);
    case (idx)
      0:       reset_value = vcg_pkg::RST_FB_DIV;
      1:       reset_value = vcg_pkg::RST_LO;
      2:       reset_value = vcg_pkg::RST_HI;
      3:       reset_value = vcg_pkg::RST_REF;
      4:       reset_value = vcg_pkg::RST_CTL4;
      5:       reset_value = vcg_pkg::RST_CTL5;
      6:       reset_value = vcg_pkg::RST_TEST;
      default: reset_value = vcg_pkg::RST_SPARE;
    endcase
  endfunction

  // frame arrives flag first, so after 15 shifts flag sits in bit 14
  assign addr = {shreg_q[11], shreg_q[12], shreg_q[13]};

  always_comb begin
    for (int i = 0; i < vcg_pkg::NUM_REGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    shreg_d = shreg_q;
    drive_d = drive_q;
    // release the data wire once a read-back frame ends
    if (sel_up) begin
      drive_d = 1'b0;
    end
    if (sclk_rise) begin
      if (!sel_lv) begin
        if (drive_q) begin
          shreg_d = {shreg_q[13:0], 1'b0};
        end else begin
          shreg_d = {shreg_q[13:0], sd_lv};
        end
      end else if (!shreg_q[14]) begin
        regs_d[addr] = {shreg_q[0], shreg_q[1], shreg_q[2], shreg_q[3],
                        shreg_q[4], shreg_q[5], shreg_q[6], shreg_q[7],
                        shreg_q[8], shreg_q[9], shreg_q[10]};
        drive_d = 1'b0;
      end else begin
        // read: reload lsb-first address then data for shifting out
        shreg_d = {1'b1, addr[0], addr[1], addr[2],
                   regs_q[addr][0], regs_q[addr][1], regs_q[addr][2],
                   regs_q[addr][3], regs_q[addr][4], regs_q[addr][5],
                   regs_q[addr][6], regs_q[addr][7], regs_q[addr][8],
                   regs_q[addr][9], regs_q[addr][10]};
        shreg_d = {shreg_d[13:0], 1'b0};
        drive_d = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // reference, feedback and detector gating
  // ---------------------------------------------------------------
  logic ref_buf, ref_edge_polarity, fb_pol, sel_r, sel_f, pd_on;
  always_comb begin
    ref_buf = regs_q[vcg_pkg::ADDR_CTL5][vcg_pkg::REF_BUF_BIT];
    ref_edge_polarity = regs_q[vcg_pkg::ADDR_REF][vcg_pkg::REF_EDGE_POLARITY_BIT];
    fb_pol  = regs_q[vcg_pkg::ADDR_CTL5][vcg_pkg::FB_POL_BIT];
    pd_on   = pd_lv & regs_q[vcg_pkg::ADDR_CTL4][vcg_pkg::PD_EN_BIT];
    sel_r   = ref_buf ? ref_r : xo_r;
    sel_f   = ref_buf ? ref_f : xo_f;
    fb_int_d = fb_int_q;
    // switch to internal only on an active external feedback edge; to external at once
    if (regs_q[vcg_pkg::ADDR_CTL5][vcg_pkg::FB_SEL_BIT] != fb_int_q) begin
      if (!regs_q[vcg_pkg::ADDR_CTL5][vcg_pkg::FB_SEL_BIT] ||
          (fb_pol ? ext_f : ext_r)) begin
        fb_int_d = regs_q[vcg_pkg::ADDR_CTL5][vcg_pkg::FB_SEL_BIT];
      end
    end
    add_d = regs_q[vcg_pkg::ADDR_CTL5][vcg_pkg::ADD_BIT];
    rem_d = regs_q[vcg_pkg::ADDR_CTL5][vcg_pkg::REMOVE_BIT];
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < vcg_pkg::NUM_REGS; i++) begin
        regs_q[i] <= reset_value(i);
      end
      shreg_q  <= 15'h0000;
      drive_q  <= 1'b0;
      fb_int_q <= 1'b1;
      add_q    <= 1'b0;
      rem_q    <= 1'b0;
      pfd_ref_edge_o <= 1'b0;
      pfd_fb_edge_o  <= 1'b0;
      pixel_add_o    <= 1'b0;
      pixel_remove_o <= 1'b0;
    end else begin
      regs_q   <= regs_d;
      shreg_q  <= shreg_d;
      drive_q  <= drive_d;
      fb_int_q <= fb_int_d;
      add_q    <= add_d;
      rem_q    <= rem_d;
      pfd_ref_edge_o <= pd_on & (ref_edge_polarity ? sel_f : sel_r);
      pfd_fb_edge_o  <= pd_on & (fb_int_q ? int_r :
                        (fb_pol ? ext_f : ext_r));
      pixel_add_o    <= add_d & ~add_q;
      pixel_remove_o <= rem_d & ~rem_q;
    end
  end

  // ---------------------------------------------------------------
  // outputs and board test
  // ---------------------------------------------------------------
  logic [10:0] test;
  assign test = regs_q[vcg_pkg::ADDR_TEST];
  always_comb begin
    if (test[vcg_pkg::TEST_EN_BIT]) begin
      clk_p_o      = test[vcg_pkg::TEST_CLK_BIT];
      clk_n_o      = ~test[vcg_pkg::TEST_CLK_BIT];
      aux_output_o = test[vcg_pkg::TEST_AUX_LSB +: 4];
    end else begin
      clk_p_o      = px_lv;
      clk_n_o      = ~px_lv;
      aux_output_o = aux_func_i;
    end
  end

  assign fb_is_internal_o = fb_int_q;
  assign fb_divider_o     = regs_q[vcg_pkg::ADDR_FB_DIV];
  assign ref_divider_o    = regs_q[vcg_pkg::ADDR_REF];
  assign ser.serial_data_io_dev_o  = shreg_q[14];
  assign ser.serial_data_io_dev_oe = drive_q & ~sel_lv & ~sclk_lv;
endmodule

// file: design/vcg_host.sv
/*
  host end: waits out power-on, then shifts one 15-bit frame per
  request and returns read data. assumes a user port on ref_clk_i.
*/
`timescale 1ns/100ps
module vcg_host (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  vcg_serial_if.host       ser,
  input  wire logic        req_i,
  input  wire logic        read_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [10:0] wdata_i,
  output logic             ready_o,
  output logic             done_o,
  output logic [10:0]      rdata_o
);
  logic                     sd_s1_q, sd_s2_q;
  vcg_pkg::vcg_host_state_t st_q, st_d;
  logic [15:0]              cnt_q, cnt_d;
  logic [4:0]               bit_q, bit_d;
  logic [14:0]              sh_q, sh_d;
  logic [10:0]              rd_q, rd_d;
  logic                     rd_q_flag, rd_flag_d;
  logic                     sclk_q, sclk_d, serial_select_n_q, serial_select_n_d, done_d;

  always_comb begin
    st_d = st_q; cnt_d = cnt_q; bit_d = bit_q; sh_d = sh_q;
    rd_d = rd_q; rd_flag_d = rd_q_flag; sclk_d = sclk_q;
    serial_select_n_d = serial_select_n_q; done_d = 1'b0;
    case (st_q)
      vcg_pkg::HOST_WAIT: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == 16'(vcg_pkg::POR_WAIT_CYC)) begin
          st_d = vcg_pkg::HOST_IDLE;
        end
      end
      vcg_pkg::HOST_IDLE: begin
        cnt_d = 16'h0000;
        if (req_i) begin
          sh_d = {read_i, addr_i[0], addr_i[1], addr_i[2],
                  wdata_i[0], wdata_i[1], wdata_i[2], wdata_i[3],
                  wdata_i[4], wdata_i[5], wdata_i[6], wdata_i[7],
                  wdata_i[8], wdata_i[9], wdata_i[10]};
          rd_flag_d = read_i;
          serial_select_n_d = 1'b0;
          bit_d = 5'h00;
          st_d = vcg_pkg::HOST_SHIFT;
        end
      end
      vcg_pkg::HOST_SHIFT: begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == 16'(vcg_pkg::SCLK_HALF_CYC - 1)) begin
          cnt_d = 16'h0000;
          sclk_d = ~sclk_q;
          if (sclk_q) begin
            sh_d = {sh_q[13:0], 1'b0};
            bit_d = bit_q + 5'h01;
            if (bit_q == 5'(vcg_pkg::FRAME_BITS - 1)) begin
              bit_d = 5'h00;
              st_d = vcg_pkg::HOST_LATCH;
            end
          end
        end
      end
      vcg_pkg::HOST_LATCH: begin
        cnt_d = cnt_q + 16'h0001;
        // select only moves one clock into a low phase
        if (!sclk_q && cnt_q == 16'h0000) begin
          if (!serial_select_n_q && bit_q == 5'h00) begin
            serial_select_n_d = 1'b1;
          end else if (serial_select_n_q && rd_q_flag && bit_q == 5'h01) begin
            serial_select_n_d = 1'b0;
          end else if (!serial_select_n_q && bit_q == 5'(vcg_pkg::FRAME_BITS)) begin
            serial_select_n_d = 1'b1;
            done_d = 1'b1;
            st_d = vcg_pkg::HOST_IDLE;
          end
        end
        if (cnt_q == 16'(vcg_pkg::SCLK_HALF_CYC - 1)) begin
          cnt_d = 16'h0000;
          sclk_d = ~sclk_q;
          if (!sclk_q && !serial_select_n_q) begin
            // read-back bit stands while the clock is low
            bit_d = bit_q + 5'h01;
            if (bit_q >= 5'h04) begin
              rd_d = {sd_s2_q, rd_q[10:1]};
            end
          end else if (sclk_q && serial_select_n_q && !rd_q_flag) begin
            done_d = 1'b1;
            st_d = vcg_pkg::HOST_IDLE;
          end else if (sclk_q && serial_select_n_q) begin
            bit_d = 5'h01;
          end
        end
      end
      default: st_d = vcg_pkg::HOST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_q <= vcg_pkg::HOST_WAIT;
      cnt_q <= 16'h0000; bit_q <= 5'h00; sh_q <= 15'h0000;
      rd_q <= 11'h000; rd_q_flag <= 1'b0;
      sclk_q <= 1'b0; serial_select_n_q <= 1'b1; done_o <= 1'b0;
      sd_s1_q <= 1'b0; sd_s2_q <= 1'b0;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; bit_q <= bit_d; sh_q <= sh_d;
      rd_q <= rd_d; rd_q_flag <= rd_flag_d;
      sclk_q <= sclk_d; serial_select_n_q <= serial_select_n_d; done_o <= done_d;
      sd_s1_q <= ser.serial_data_io; sd_s2_q <= sd_s1_q;
    end
  end

  assign ready_o           = (st_q == vcg_pkg::HOST_IDLE);
  assign rdata_o           = rd_q;
  assign ser.sclk          = sclk_q;
  assign ser.sel_n         = serial_select_n_q;
  assign ser.serial_data_io_host_o  = sh_q[14];
  assign ser.serial_data_io_host_oe = (st_q == vcg_pkg::HOST_SHIFT);
endmodule

// file: verification/vcg_link_asserts.sv
/*
  link checker: timing and framing of the three-wire serial link.
  assumes it sits beside the interface, on ref_clk_i and sys_rst_i.
*/
`timescale 1ns/100ps
module vcg_link_asserts (
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic sclk,
  input  wire logic sel_n,
  input  wire logic serial_data_io_host_o,
  input  wire logic serial_data_io_host_oe,
  input  wire logic serial_data_io_dev_o,
  input  wire logic serial_data_io_dev_oe,
  input  wire logic serial_data_io
);
  // -------------------------------------------------
  // helper counters
  // -------------------------------------------------
  logic [11:0] por_q, por_d;
  logic [4:0]  bits_q, bits_d;
  logic        sclk_q, sclk_d;

  always_comb begin
    por_d  = (por_q == 12'hfff) ? por_q : por_q + 12'h001;
    bits_d = sel_n ? 5'h00 : bits_q + {4'h0, sclk & ~sclk_q};
    sclk_d = sclk;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      por_q  <= 12'h000;
      bits_q <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      por_q  <= por_d;
      bits_q <= bits_d;
      sclk_q <= sclk_d;
    end
  end

  // -------------------------------------------------
  // link properties
  // -------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_high_phase;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence s_latch_edge;
    ##[1:40] $rose(sclk);
  endsequence

  property p_por_wait;
    !sel_n |-> por_q >= 12'(vcg_pkg::POR_WAIT_CYC);
  endproperty
  a_por_wait: assert property (p_por_wait)
    else $error("select asserted before power-on wait");
  property p_reset_idle;
    $fell(sys_rst_i) |-> sel_n && !sclk && !serial_data_io_dev_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("link not idle after reset");
  property p_dev_quiet;
    sel_n [*5] |-> !serial_data_io_dev_oe;
  endproperty
  a_dev_quiet: assert property (p_dev_quiet)
    else $error("device drives data while deselected");
  property p_no_contention;
    !(serial_data_io_host_oe && serial_data_io_dev_oe);
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("both ends drive the data wire");
  property p_sel_edges;
    !$stable(sel_n) |-> !sclk && !$past(sclk);
  endproperty
  a_sel_edges: assert property (p_sel_edges)
    else $error("select moved while serial clock high");
  property p_sclk_high;
    $rose(sclk) |-> s_high_phase;
  endproperty
  a_sclk_high: assert property (p_sclk_high)
    else $error("serial clock high phase length wrong");
  property p_frame_bits;
    $rose(sel_n) |-> bits_q == 5'd15 || bits_q == 5'd14;
  endproperty
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame bit count wrong");
  property p_latch;
    $rose(sel_n) && bits_q == 5'd15 |-> sel_n throughout s_latch_edge;
  endproperty
  a_latch: assert property (p_latch)
    else $error("no latch edge with select high");
endmodule

// file: verification/pll_ref_feedback_control_test.sv
/*
  bench: host and device ends on one link, driven from the user side.
  assumes design files and the link checker compile before this file.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  failures++; $display("CHECK FAILED t=%0t %h %h", $time, a, e); end end
module pll_ref_feedback_control_test;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        ref_clk_i;
  logic        sys_rst_i = 1'b1;
  logic        req_i = 1'b0;
  logic        read_i = 1'b0;
  logic [2:0]  addr_i = 3'h0;
  logic [10:0] wdata_i = 11'h000;
  logic [3:0]  pins = 4'h0;
  logic [3:0]  aux_func_i = 4'h0;
  logic        phase_detect_enable_i = 1'b1;
  logic        pixel_clk_i = 1'b0;
  logic        ready_o, done_o, fb_is_internal_o, pfd_ref_edge_o;
  logic        pfd_fb_edge_o, pixel_add_o, pixel_remove_o, clk_p_o, clk_n_o;
  logic [10:0] rdata_o, fb_divider_o, ref_divider_o, q;
  logic [3:0]  aux_output_o;
  logic [5:0]  lv;
  int          rc, fc, ac, mc, cyc, r0, failures, samples_checked;
  int          mdl [8];
  int          d [2];

  vcg_serial_if ser_if ();
  vcg_host vcg_host_i (.ref_clk_i, .sys_rst_i, .ser(ser_if.host), .req_i,
    .read_i, .addr_i, .wdata_i, .ready_o, .done_o, .rdata_o);
  vcg_device vcg_device_i (.ref_clk_i, .sys_rst_i, .ser(ser_if.device),
    .crystal_osc_i(pins[0]), .reference_input_i(pins[1]),
    .ext_feedback_input_i(pins[2]), .int_feedback_i(pins[3]),
    .phase_detect_enable_i, .pixel_clk_i, .aux_func_i, .pfd_ref_edge_o,
    .pfd_fb_edge_o, .fb_is_internal_o, .pixel_add_o, .pixel_remove_o,
    .clk_p_o, .clk_n_o, .aux_output_o, .fb_divider_o, .ref_divider_o);
  vcg_link_asserts vcg_link_asserts_i (.ref_clk_i, .sys_rst_i,
    .sclk(ser_if.sclk), .sel_n(ser_if.sel_n),
    .serial_data_io_host_o(ser_if.serial_data_io_host_o),
    .serial_data_io_host_oe(ser_if.serial_data_io_host_oe),
    .serial_data_io_dev_o(ser_if.serial_data_io_dev_o), .serial_data_io_dev_oe(ser_if.serial_data_io_dev_oe),
    .serial_data_io(ser_if.serial_data_io));

  // ---------------------------------------------------------------
  // clock, pulse counters, watchdog
  // ---------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  always @(negedge ref_clk_i) begin
    rc += (pfd_ref_edge_o === 1'b1);
    fc += (pfd_fb_edge_o === 1'b1);
    ac += (pixel_add_o === 1'b1);
    mc += (pixel_remove_o === 1'b1);
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic rd, input int a, input int v);
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 5000) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    req_i <= 1'b1;
    read_i <= rd;
    addr_i <= a[2:0];
    wdata_i <= v[10:0];
    @(posedge ref_clk_i);
    req_i <= 1'b0;
    do begin
      @(negedge ref_clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 9000);
    failures += (n >= 9000);
    q = rdata_o;
  endtask
  task automatic wr(input int a, input int v);
    xfer(1'b0, a, v);
    mdl[a] = v % 2048;
  endtask
  task automatic rdc(input int a);
    xfer(1'b1, a, 0);
    `CHK(q, mdl[a][10:0])
  endtask
  task automatic pulse(input int p);
    int r, f;
    for (int v = 1; v >= 0; v--) begin
      r = rc;
      f = fc;
      @(posedge ref_clk_i);
      pins[p] <= v[0];
      repeat (10) @(posedge ref_clk_i);
      d[v] = (rc - r) * 16 + fc - f;
    end
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32910));
    mdl = '{11'h04f, 11'h003, 11'h006, 11'h013, 11'h5c4, 11'h031, 0, 0};
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rdc(a);
    end
    `CHK(fb_divider_o, 11'h04f)
    `CHK(fb_is_internal_o, 1'b1)
    $display("test defaults done");
    for (int a = 0; a < 8; a++) begin
      wr(a, $urandom);
    end
    for (int a = 0; a < 8; a++) begin
      rdc(a);
    end
    `CHK(ref_divider_o, mdl[3][10:0])
    wr(4, 'h5c4);
    wr(6, 0);
    $display("test random registers done");
    for (int c = 0; c < 4; c++) begin
      wr(3, (c / 2) * 1024);
      wr(5, 'h031 | (c % 2) * 64);
      for (int p = 0; p < 2; p++) begin
        pulse(p);
        `CHK(d[1], (p == c % 2 && c < 2) ? 16 : 0)
        `CHK(d[0], (p == c % 2 && c > 1) ? 16 : 0)
      end
    end
    @(posedge ref_clk_i);
    phase_detect_enable_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    pulse(1);
    `CHK(d[1] + d[0], 0)
    phase_detect_enable_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    pulse(1);
    `CHK(d[0], 16)
    $display("test reference path done");
    for (int p = 0; p < 2; p++) begin
      wr(5, 'h030 | p * 2);
      `CHK(fb_is_internal_o, 1'b0)
      pulse(2);
      `CHK(d[1], 1 - p)
      `CHK(d[0], p)
      pulse(3);
      `CHK(d[1] + d[0], 0)
    end
    wr(5, 'h031);
    `CHK(fb_is_internal_o, 1'b0)
    pulse(2);
    `CHK(fb_is_internal_o, 1'b1)
    pulse(2);
    `CHK(d[1] + d[0], 0)
    $display("test feedback path done");
    for (int k = 0; k < 6; k++) begin
      r0 = ac * 16 + mc;
      wr(5, 'h031 | ((k % 3 < 2) ? 4 << (k / 3) : 0));
      repeat (8) @(posedge ref_clk_i);
      `CHK(ac * 16 + mc - r0, (k % 3) ? 0 : (k < 3 ? 16 : 1))
    end
    $display("test pixel add remove done");
    for (int t = 0; t < 4; t++) begin
      lv = 6'($urandom);
      wr(6, (lv & 6'h3e) | 1);
      repeat (8) @(negedge ref_clk_i);
      `CHK(aux_output_o, lv[5:2])
      `CHK(clk_p_o, lv[1])
      `CHK(clk_n_o, ~lv[1])
    end
    @(posedge ref_clk_i);
    aux_func_i <= 4'($urandom);
    pixel_clk_i <= 1'b1;
    wr(6, 0);
    repeat (8) @(negedge ref_clk_i);
    `CHK(aux_output_o, aux_func_i)
    `CHK(clk_p_o, 1'b1)
    $display("test board test done");
    end_sim();
  end
endmodule
